// ===== design/cds_counter.sv
// Counter/delay unit with synchronised reset and coherent snapshot readout
//
// Notes on behaviour
// - Counter reset passes two flip-flops on clk before use.
// - Eight-bit count readable by host; down-count mode supported.
// - Host read request raises latch strobe copying count into read register.
// - Snapshot strobe never disturbs the running count.
// - Matrix source with nothing routed holds counter clock low, counting stops.
// - With clock stopped, every read returns the exact stable count.
`timescale 1ns/100ps
module cds_counter #(
    parameter int unsigned WIDTH = cds_pkg::COUNT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             cntResetIn,
    input  wire logic             oscTick,
    input  wire logic             matrixTick,
    input  wire logic             matrixRouted,
    input  wire logic             srcSelMatrix,
    input  wire logic             countDown,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             readReq,
    output logic      [WIDTH-1:0] readData,
    output logic                  readValid,
    output logic      [WIDTH-1:0] countValue,
    output logic                  countOut
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int unsigned NUM_SYNC = 5;

    logic                cntResetSync;
    logic                oscSync;
    logic                matrixSync;
    logic                routedSync;
    logic                reqSync;
    logic [NUM_SYNC-1:0] asyncVec;
    logic [NUM_SYNC-1:0] syncVec;

    // Pins from other clock domains; bit order matches the unpack below
    assign asyncVec = {readReq, matrixRouted, matrixTick, oscTick, cntResetIn};

    // One two-stage synchroniser per pin; only its second stage is read here
    for (genvar i = 0; i < NUM_SYNC; i++) begin : gSync
        cds_sync uSync (
            .clk     (clk),
            .rst_b   (rst_b),
            .asyncIn (asyncVec[i]),
            .syncOut (syncVec[i])
        );
    end

    // Synchronised copies under their working names
    assign cntResetSync = syncVec[0];
    assign oscSync      = syncVec[1];
    assign matrixSync   = syncVec[2];
    assign routedSync   = syncVec[3];
    assign reqSync      = syncVec[4];

    // ************************************************************
    // Counter state
    // ************************************************************
    logic [WIDTH-1:0] count_q,    count_d;
    logic [WIDTH-1:0] snap_q,     snap_d;
    logic             tickPrev_q, tickPrev_d;
    logic             reqPrev_q,  reqPrev_d;
    logic             valid_q,    valid_d;
    logic             out_q,      out_d;
    logic             cntClk;
    logic             tickEdge;
    logic             latchStrobe;

    // Selected counter clock; unrouted matrix source is tied low
    // Changing source while the new one is high and the old one low counts one extra edge
    always_comb begin
        if (srcSelMatrix == 1'(cds_pkg::CDS_SRC_MATRIX))
            cntClk = matrixSync & routedSync;
        else
            cntClk = oscSync;
    end

    // Rising edges of the counter clock and read request; a held request strobes once
    assign tickEdge    = cntClk & ~tickPrev_q;
    assign latchStrobe = reqSync & ~reqPrev_q;

    // Next values for count, snapshot and outputs
    always_comb begin
        count_d    = count_q;
        snap_d     = snap_q;
        tickPrev_d = cntClk;
        reqPrev_d  = reqSync;
        valid_d    = latchStrobe;
        out_d      = 1'b0;
        if (cntResetSync) begin
            count_d = loadValue;
        end else if (tickEdge) begin
            if (countDown) begin
                if (count_q == '0) begin
                    count_d = loadValue;
                    out_d   = 1'b1;
                end else begin
                    count_d = count_q - 1'b1;
                end
            end else begin
                if (count_q == loadValue) begin
                    count_d = '0;
                    out_d   = 1'b1;
                end else begin
                    count_d = count_q + 1'b1;
                end
            end
        end
        // Snapshot takes the whole registered count in one edge
        if (latchStrobe)
            snap_d = count_q;
        if (!rst_b) begin
            count_d    = WIDTH'(cds_pkg::COUNT_RESET_VAL);
            snap_d     = WIDTH'(cds_pkg::COUNT_RESET_VAL);
            tickPrev_d = 1'b0;
            reqPrev_d  = 1'b0;
            valid_d    = 1'b0;
            out_d      = 1'b0;
        end
    end

    // Register state
    always_ff @(posedge clk) begin
        count_q    <= count_d;
        snap_q     <= snap_d;
        tickPrev_q <= tickPrev_d;
        reqPrev_q  <= reqPrev_d;
        valid_q    <= valid_d;
        out_q      <= out_d;
    end

    // Outputs driven from flip-flops
    assign readData   = snap_q;
    assign readValid  = valid_q;
    assign countValue = count_q;
    assign countOut   = out_q;

    // ************************************************************
    // Assertions: snapshot path
    // ************************************************************
    snap_exact_a: assert property (@(posedge clk) disable iff (!rst_b)
        latchStrobe |=> (readData == $past(count_q)) && readValid)
        else $error("snapshot does not match count");

    snap_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !latchStrobe |=> readData == $past(snap_q))
        else $error("snapshot changed without strobe");

    stopped_snap_a: assert property (@(posedge clk) disable iff (!rst_b)
        (latchStrobe && !tickEdge && !cntResetSync) |=> readData == countValue)
        else $error("snapshot differs from a standing count");

    valid_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        readValid |=> !readValid)
        else $error("latch strobe longer than one cycle");

    valid_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        !latchStrobe |=> !readValid)
        else $error("read valid without a latch strobe");

    req_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        (reqSync && reqPrev_q) |=> !readValid)
        else $error("held read request gave a second snapshot");

    // ************************************************************
    // Assertions: count path
    // ************************************************************
    count_undisturbed_a: assert property (@(posedge clk) disable iff (!rst_b)
        (latchStrobe && !tickEdge && !cntResetSync) |=> countValue == $past(count_q))
        else $error("strobe disturbed count");

    stopped_stable_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!tickEdge && !cntResetSync) |=> countValue == $past(count_q))
        else $error("count moved without a tick");

    down_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        (tickEdge && countDown && !cntResetSync && count_q != '0)
        |=> countValue == $past(count_q) - 1'b1)
        else $error("down count step wrong");

    up_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        (tickEdge && !countDown && !cntResetSync && count_q != loadValue)
        |=> countValue == $past(count_q) + 1'b1)
        else $error("up count step wrong");

    down_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        (tickEdge && countDown && !cntResetSync && count_q == '0)
        |=> (countValue == $past(loadValue)) && countOut)
        else $error("down count did not reload with a pulse");

    up_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        (tickEdge && !countDown && !cntResetSync && count_q == loadValue)
        |=> (countValue == '0) && countOut)
        else $error("up count did not wrap with a pulse");

    out_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!tickEdge || cntResetSync) |=> !countOut)
        else $error("wrap pulse without a counted edge");

    reset_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        cntResetSync |=> countValue == $past(loadValue))
        else $error("counter reset did not load the reload value");

    reset_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        cntResetSync |=> !countOut)
        else $error("counter reset gave a wrap pulse");

    // ************************************************************
    // Assertions: synchroniser and clock select
    // ************************************************************
    reset_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cntResetIn) |-> ##1 !cntResetSync ##1 cntResetSync)
        else $error("counter reset not synchronised in two stages");

    unrouted_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        (srcSelMatrix && !routedSync) |-> !tickEdge)
        else $error("counter ticked with unrouted matrix clock");
endmodule

// ===== design/cds_pkg.sv
// Package with constants for the counter/delay snapshot readout block
package cds_pkg;
    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int unsigned COUNT_WIDTH     = 8;
    localparam int unsigned SYNC_STAGES     = 2;
    localparam logic [7:0]  COUNT_RESET_VAL = 8'h00;
    localparam logic [7:0]  LOAD_RESET_VAL  = 8'hFF;

    // ************************************************************
    // Clock source selection
    // ************************************************************
    typedef enum logic [0:0] {
        CDS_SRC_OSC,
        CDS_SRC_MATRIX
    } cds_src_e;
endpackage

// ===== design/cds_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module cds_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_q;
    logic stage1_d;
    logic syncOut_q;
    logic syncOut_d;

    // Next values: first stage feeds only the second
    always_comb begin
        stage1_d  = asyncIn;
        syncOut_d = stage1_q;
        if (!rst_b) begin
            stage1_d  = 1'b0;
            syncOut_d = 1'b0;
        end
    end

    // Register stages
    always_ff @(posedge clk) begin
        stage1_q  <= stage1_d;
        syncOut_q <= syncOut_d;
    end

    // Output straight from the second stage
    assign syncOut = syncOut_q;
endmodule

// ===== verification/cds_host_model.sv
// Host model that requests count snapshots and collects the read register
`timescale 1ns/100ps
module cds_host_model (
    input  wire logic       clk,
    output logic            readReq,
    input  wire logic [7:0] readData,
    input  wire logic       readValid
);
    int missCount;

    // Idle request and no missed answers at start
    initial begin
        readReq   = 1'b0;
        missCount = 0;
    end

    // One snapshot read, held until the answer is seen, then a quiet gap
    task automatic read_count(output logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        readReq <= 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (readValid !== 1'b1 && n < 20);
        if (readValid !== 1'b1)
            missCount++;
        v = readData;
        @(posedge clk);
        readReq <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ===== verification/counter_delay_snapshot_readout_tb.sv
// Self-checking bench for the counter/delay snapshot readout block
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module counter_delay_snapshot_readout_tb;
    logic       clk, rst_b, cntResetIn, oscTick, matrixTick, matrixRouted;
    logic       srcSelMatrix, countDown, readReq, readValid, countOut;
    logic [7:0] loadValue, readData, countValue, rd;
    int         bad_count, cmp_count, cyc, wrapCount;

    cds_counter #(.WIDTH(8)) dut (.clk(clk), .rst_b(rst_b), .cntResetIn(cntResetIn),
        .oscTick(oscTick), .matrixTick(matrixTick), .matrixRouted(matrixRouted),
        .srcSelMatrix(srcSelMatrix), .countDown(countDown), .loadValue(loadValue),
        .readReq(readReq), .readData(readData), .readValid(readValid),
        .countValue(countValue), .countOut(countOut));
    cds_host_model host (.clk(clk), .readReq(readReq), .readData(readData),
        .readValid(readValid));

    // ************************************************************
    // Clock, watchdog and helpers
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cycle watchdog and count of wrap pulses
    always @(posedge clk) begin
        cyc++;
        if (countOut === 1'b1)
            wrapCount++;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end
    // One counter clock pulse on both sources, four cycles high and low
    task automatic tick();
        @(posedge clk);
        oscTick <= 1'b1;
        matrixTick <= 1'b1;
        repeat (4) @(posedge clk);
        oscTick <= 1'b0;
        matrixTick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic final_report();
        bad_count += host.missCount;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_up();
        `CHK(countValue, 8'h00)
        repeat (2) tick();
        host.read_count(rd);
        `CHK(rd, 8'h02)
        repeat (2) tick();
        `CHK(countValue, 8'h00)
        `CHK(wrapCount, 1)
        $display("test up done");
    endtask
    task automatic t_down();
        @(posedge clk);
        countDown <= 1'b1;
        cntResetIn <= 1'b1;
        repeat (4) @(posedge clk);
        cntResetIn <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(countValue, 8'h03)
        tick();
        `CHK(countValue, 8'h02)
        $display("test down done");
    endtask
    task automatic t_race();
        fork
            tick();
            host.read_count(rd);
        join
        `CHK(countValue, 8'h01)
        `CHK((rd === 8'h02) || (rd === 8'h01), 1'b1)
        $display("test race done");
    endtask
    task automatic t_stop();
        @(posedge clk);
        srcSelMatrix <= 1'b1;
        repeat (2) tick();
        `CHK(countValue, 8'h01)
        repeat (2) begin
            host.read_count(rd);
            `CHK(rd, 8'h01)
        end
        matrixRouted <= 1'b1;
        tick();
        `CHK(countValue, 8'h00)
        tick();
        `CHK(countValue, 8'h03)
        `CHK(wrapCount, 2)
        $display("test stop done");
    endtask

    initial begin
        {cntResetIn, oscTick, matrixTick, matrixRouted, srcSelMatrix, countDown} = '0;
        rst_b = 1'b0;
        loadValue = 8'h03;
        bad_count = 0;
        cmp_count = 0;
        cyc = 0;
        wrapCount = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_up();
        t_down();
        t_race();
        t_stop();
        final_report();
    end
endmodule
